// ==== verilog/cwm_core.sv ====
// Complementary waveform mode core: one selected pulse input, four drive outputs.
// Assumes an Avalon-MM master on ref_clk; pulse and shutdown inputs are asynchronous.
// What this block does
// - One pulse input in every mode feeds up to four outputs.
// - Three-bit mode field selects one of six operating modes.
// - Off-to-on of one output is delayed after the other turns off.
// - Independent 6-bit rising and falling dead-band timers, each enabled separately.
// - Auto-shutdown in all modes: sources, auto-restart, override levels; in 000/001 unsteered outputs keep their steering data.
// - Half-bridge: A follows input, B inverse, dead band, never overlap.
// - Steering is unavailable in half-bridge mode.
// - Half-bridge: C and D mirror A and B with own polarity.
// - Push-pull: successive pulses alternate between A and B, no steering.
// - Push-pull sequencer resets when disabled or on shutdown.
// - After sequencer reset the first pulse appears on A.
// - Push-pull: C copies A, D copies B, own polarity each.
// - Full-bridge: three static outputs, one modulated, no steering.
// - Code 010: A active, B and C inactive, D modulated.
// - Code 011: C active, A and D inactive, B modulated.
// - Forward/reverse toggle by mode bit zero is accepted while enabled.
// - Full-bridge dead band only on a direction change.
// - Each output has its own polarity control.
// - 001 steering applies at input rise; 000 applies at once.
// - Direction changes at input rise; modulation resumes after dead band.
// - Dead band counts clock periods from zero up to programmed count.
// - Polarity set means active-high; overrides ignore polarity.
`timescale 1ns/1ps
module cwm_core
#(
  parameter logic [2:0] MODE_HB = cwm_pkg::CWM_MODE_HB_DEF,
  parameter logic [2:0] MODE_PP = cwm_pkg::CWM_MODE_PP_DEF
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire cwm_pkg::cwm_av_req_s avs_req,
  output logic [cwm_pkg::CWM_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [cwm_pkg::CWM_NSRC-1:0] pulse_src,
  input wire logic [cwm_pkg::CWM_NSD-1:0] shutdown_src,
  output logic drive_out_a,
  output logic drive_out_b,
  output logic drive_out_c,
  output logic drive_out_d,
  output logic shutdown_active
);
  import cwm_pkg::*;

  if (MODE_HB == MODE_PP || MODE_HB[2:1] == CWM_FB_HI || MODE_PP[2:1] == CWM_FB_HI
      || MODE_HB[2:1] == 2'h0 || MODE_PP[2:1] == 2'h0)
  begin
    $error("cwm_core: half-bridge and push-pull codes must be distinct and unused");
  end

  function automatic logic pol_apply(input logic raw, input logic pol);
    pol_apply = pol ? raw : ~raw;
  endfunction

  function automatic logic db_done(input logic en, input logic [CWM_DB_W-1:0] cnt,
                                   input logic [CWM_DB_W-1:0] lim);
    db_done = !en || cnt == lim;
  endfunction

  cwm_cfg_s cfg_reg;
  logic wait_reg;
  logic [CWM_DW-1:0] rdata_reg;
  logic [CWM_NSRC-1:0] src_s1_reg, src_s2_reg;
  logic [CWM_NSD-1:0] sd_s1_reg, sd_s2_reg;
  logic sel_reg, sel_d_reg;
  logic shut_reg;
  logic hb_a_reg, hb_b_reg;
  logic [CWM_DB_W-1:0] rcnt_reg, fcnt_reg, fb_cnt_reg;
  logic pp_next_reg, pp_cur_reg;
  logic fb_dir_reg, fb_dead_reg;
  logic [CWM_NOUT-1:0] str_eff_reg;
  logic [CWM_NOUT-1:0] drive_reg;
  logic [CWM_NOUT-1:0] raw_next;
  logic [CWM_NOUT-1:0] drive_next;
  logic rise, sd_hit, is_fb, is_steer, pp_b, fb_limit_en;
  logic [CWM_DB_W-1:0] fb_limit;
  logic wr_go, rd_go;

  assign wr_go = avs_req.write && !wait_reg;
  assign rd_go = avs_req.read && wait_reg;
  assign rise = sel_reg && !sel_d_reg;
  assign sd_hit = (|(cfg_reg.sd_en & sd_s2_reg)) || cfg_reg.sd_sw;
  assign is_fb = cfg_reg.mode[2:1] == CWM_FB_HI;
  assign is_steer = cfg_reg.mode == CWM_MODE_ASYNC || cfg_reg.mode == CWM_MODE_SYNC;

  // Bus answers one cycle after the request appears; waitrequest idles high
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      wait_reg <= 1'b1;
    else if ((avs_req.read || avs_req.write) && wait_reg)
      wait_reg <= 1'b0;
    else
      wait_reg <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_reg <= '0;
      cfg_reg.pol <= CWM_POL_RST;
    end
    else if (wr_go)
    begin
      case (avs_req.address)
        CWM_OFS_CTRL0:
        begin
          cfg_reg.en <= avs_req.writedata[CWM_EN_BIT];
          cfg_reg.mode <= avs_req.writedata[2:0];
        end
        CWM_OFS_CTRL1: cfg_reg.pol <= avs_req.writedata[CWM_NOUT-1:0];
        CWM_OFS_DBR: cfg_reg.dbr <= avs_req.writedata[CWM_DB_W-1:0];
        CWM_OFS_DBF: cfg_reg.dbf <= avs_req.writedata[CWM_DB_W-1:0];
        CWM_OFS_DBEN:
        begin
          cfg_reg.dbr_en <= avs_req.writedata[CWM_DBR_EN_BIT];
          cfg_reg.dbf_en <= avs_req.writedata[CWM_DBF_EN_BIT];
        end
        CWM_OFS_ISEL: cfg_reg.isel <= avs_req.writedata[CWM_SEL_W-1:0];
        CWM_OFS_SHUT:
        begin
          cfg_reg.sd_en <= avs_req.writedata[CWM_SD_EN_LSB +: CWM_NSD];
          cfg_reg.sd_sw <= avs_req.writedata[CWM_SD_SW_BIT];
          cfg_reg.auto_rst <= avs_req.writedata[CWM_AUTO_BIT];
          cfg_reg.ovr <= avs_req.writedata[CWM_OVR_LSB +: CWM_NOUT];
        end
        CWM_OFS_STEER:
        begin
          cfg_reg.str <= avs_req.writedata[CWM_NOUT-1:0];
          cfg_reg.sdat <= avs_req.writedata[CWM_SDAT_LSB +: CWM_NOUT];
        end
        default: cfg_reg <= cfg_reg;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_reg <= '0;
    else if (rd_go)
    begin
      rdata_reg <= '0;
      case (avs_req.address)
        CWM_OFS_CTRL0:
        begin
          rdata_reg[CWM_EN_BIT] <= cfg_reg.en;
          rdata_reg[2:0] <= cfg_reg.mode;
        end
        CWM_OFS_CTRL1: rdata_reg[CWM_NOUT-1:0] <= cfg_reg.pol;
        CWM_OFS_DBR: rdata_reg[CWM_DB_W-1:0] <= cfg_reg.dbr;
        CWM_OFS_DBF: rdata_reg[CWM_DB_W-1:0] <= cfg_reg.dbf;
        CWM_OFS_DBEN:
        begin
          rdata_reg[CWM_DBR_EN_BIT] <= cfg_reg.dbr_en;
          rdata_reg[CWM_DBF_EN_BIT] <= cfg_reg.dbf_en;
        end
        CWM_OFS_ISEL: rdata_reg[CWM_SEL_W-1:0] <= cfg_reg.isel;
        CWM_OFS_SHUT:
        begin
          rdata_reg[CWM_SD_EN_LSB +: CWM_NSD] <= cfg_reg.sd_en;
          rdata_reg[CWM_SD_SW_BIT] <= cfg_reg.sd_sw;
          rdata_reg[CWM_AUTO_BIT] <= cfg_reg.auto_rst;
          rdata_reg[CWM_OVR_LSB +: CWM_NOUT] <= cfg_reg.ovr;
          rdata_reg[CWM_SHUT_BIT] <= shut_reg;
        end
        CWM_OFS_STEER:
        begin
          rdata_reg[CWM_NOUT-1:0] <= cfg_reg.str;
          rdata_reg[CWM_SDAT_LSB +: CWM_NOUT] <= cfg_reg.sdat;
        end
        CWM_OFS_STAT:
          rdata_reg[CWM_NOUT+3:0] <= {shut_reg, pp_cur_reg, fb_dir_reg, fb_dead_reg, drive_reg};
        default: rdata_reg <= '0;
      endcase
    end
  end

  // Two-stage synchronisers; only the second stage feeds logic
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      src_s1_reg <= '0;
      src_s2_reg <= '0;
      sd_s1_reg <= '0;
      sd_s2_reg <= '0;
      sel_reg <= 1'b0;
      sel_d_reg <= 1'b0;
    end
    else
    begin
      src_s1_reg <= pulse_src;
      src_s2_reg <= src_s1_reg;
      sd_s1_reg <= shutdown_src;
      sd_s2_reg <= sd_s1_reg;
      sel_reg <= src_s2_reg[cfg_reg.isel];
      sel_d_reg <= sel_reg;
    end
  end

  // Source present wins over a restart or a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      shut_reg <= 1'b0;
    else if (!cfg_reg.en)
      shut_reg <= 1'b0;
    else if (sd_hit)
      shut_reg <= 1'b1;
    else if (cfg_reg.auto_rst && rise)
      shut_reg <= 1'b0;
    else if (wr_go && avs_req.address == CWM_OFS_SHUT && avs_req.writedata[CWM_SHUT_BIT])
      shut_reg <= 1'b0;
  end

  // Half-bridge edges: turn-off is immediate, turn-on waits for its dead-band count
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hb_a_reg <= 1'b0;
      rcnt_reg <= '0;
    end
    else if (!sel_reg)
    begin
      hb_a_reg <= 1'b0;
      rcnt_reg <= '0;
    end
    else if (!hb_a_reg)
    begin
      if (db_done(cfg_reg.dbr_en, rcnt_reg, cfg_reg.dbr))
        hb_a_reg <= 1'b1;
      else
        rcnt_reg <= rcnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hb_b_reg <= 1'b0;
      fcnt_reg <= '0;
    end
    else if (sel_reg)
    begin
      hb_b_reg <= 1'b0;
      fcnt_reg <= '0;
    end
    else if (!hb_b_reg)
    begin
      if (db_done(cfg_reg.dbf_en, fcnt_reg, cfg_reg.dbf))
        hb_b_reg <= 1'b1;
      else
        fcnt_reg <= fcnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pp_next_reg <= 1'b0;
      pp_cur_reg <= 1'b0;
    end
    else if (!cfg_reg.en || shut_reg)
    begin
      pp_next_reg <= 1'b0;
      pp_cur_reg <= 1'b0;
    end
    else if (rise)
    begin
      pp_cur_reg <= pp_next_reg;
      pp_next_reg <= ~pp_next_reg;
    end
  end

  // Reverse dead band times forward-to-reverse, forward dead band the other way
  assign fb_limit = fb_dir_reg ? cfg_reg.dbr : cfg_reg.dbf;
  assign fb_limit_en = fb_dir_reg ? cfg_reg.dbr_en : cfg_reg.dbf_en;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fb_dir_reg <= 1'b0;
      fb_dead_reg <= 1'b0;
      fb_cnt_reg <= '0;
    end
    else if (!cfg_reg.en || !is_fb)
    begin
      // The write that enables a full-bridge mode sets its direction at once
      fb_dir_reg <= (wr_go && avs_req.address == CWM_OFS_CTRL0) ?
                    avs_req.writedata[0] : cfg_reg.mode[0];
      fb_dead_reg <= 1'b0;
      fb_cnt_reg <= '0;
    end
    else if (rise && cfg_reg.mode[0] != fb_dir_reg)
    begin
      fb_dir_reg <= cfg_reg.mode[0];
      fb_dead_reg <= 1'b1;
      fb_cnt_reg <= '0;
    end
    else if (fb_dead_reg)
    begin
      if (db_done(fb_limit_en, fb_cnt_reg, fb_limit))
        fb_dead_reg <= 1'b0;
      else
        fb_cnt_reg <= fb_cnt_reg + 1'b1;
    end
  end

  // Asynchronous steering loads at once; synchronous waits for an input rise
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      str_eff_reg <= '0;
    else if (!cfg_reg.en || cfg_reg.mode == CWM_MODE_ASYNC)
      str_eff_reg <= cfg_reg.str;
    else if (cfg_reg.mode == CWM_MODE_SYNC && rise)
      str_eff_reg <= cfg_reg.str;
  end

  // A rise in this cycle already belongs to the next sequencer slot
  assign pp_b = rise ? pp_next_reg : pp_cur_reg;

  always_comb
  begin
    raw_next = '0;
    if (cfg_reg.mode == MODE_HB)
      raw_next = {hb_b_reg, hb_a_reg, hb_b_reg, hb_a_reg};
    else if (cfg_reg.mode == MODE_PP)
      raw_next = {sel_reg & pp_b, sel_reg & ~pp_b, sel_reg & pp_b, sel_reg & ~pp_b};
    else if (is_fb)
      raw_next = {~fb_dir_reg & sel_reg & ~fb_dead_reg, fb_dir_reg,
                  fb_dir_reg & sel_reg & ~fb_dead_reg, ~fb_dir_reg};
  end

  // Steering exists only in the two steering modes; other modes ignore it
  always_comb
  begin
    drive_next = '0;
    for (int i = 0; i < CWM_NOUT; i++)
    begin
      if (!cfg_reg.en)
        drive_next[i] = pol_apply(1'b0, cfg_reg.pol[i]);
      else if (is_steer)
      begin
        if (!str_eff_reg[i])
          drive_next[i] = cfg_reg.sdat[i];
        else if (shut_reg)
          drive_next[i] = cfg_reg.ovr[i];
        else
          drive_next[i] = pol_apply(sel_reg, cfg_reg.pol[i]);
      end
      else if (shut_reg)
        drive_next[i] = cfg_reg.ovr[i];
      else
        drive_next[i] = pol_apply(raw_next[i], cfg_reg.pol[i]);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      drive_reg <= '0;
    else
      drive_reg <= drive_next;
  end

  assign drive_out_a = drive_reg[0];
  assign drive_out_b = drive_reg[1];
  assign drive_out_c = drive_reg[2];
  assign drive_out_d = drive_reg[3];
  assign shutdown_active = shut_reg;
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;

  hb_no_overlap_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(hb_a_reg && hb_b_reg))
    else $error("half-bridge outputs overlap");

  hb_rise_count_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(hb_a_reg) && $past(cfg_reg.dbr_en) |-> $past(rcnt_reg) == $past(cfg_reg.dbr))
    else $error("rising dead band ended at wrong count");

  pp_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !cfg_reg.en || shut_reg |=> !pp_next_reg && !pp_cur_reg)
    else $error("push-pull sequencer not reset");

  pp_first_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfg_reg.en && !shut_reg && cfg_reg.mode == MODE_PP && rise && !pp_next_reg && !sd_hit
    |=> drive_out_a == $past(cfg_reg.pol[0]) && drive_out_b == !$past(cfg_reg.pol[1]))
    else $error("first push-pull pulse not on A");

  fb_switch_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfg_reg.en && is_fb && rise && cfg_reg.mode[0] != fb_dir_reg && !wr_go
    |=> fb_dead_reg && fb_dir_reg == $past(cfg_reg.mode[0]))
    else $error("direction change not taken at input rise");

  fb_dead_mute_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fb_dead_reg |-> !raw_next[1] && !raw_next[3])
    else $error("modulated output active during dead band");

  fwd_levels_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfg_reg.en && !shut_reg && cfg_reg.mode == CWM_MODE_FWD && !fb_dir_reg
    |=> drive_out_a == $past(cfg_reg.pol[0]) && drive_out_b == !$past(cfg_reg.pol[1])
        && drive_out_c == !$past(cfg_reg.pol[2]))
    else $error("forward full-bridge static levels wrong");

  rev_levels_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfg_reg.en && !shut_reg && cfg_reg.mode == CWM_MODE_REV && fb_dir_reg
    |=> drive_out_c == $past(cfg_reg.pol[2]) && drive_out_a == !$past(cfg_reg.pol[0])
        && drive_out_d == !$past(cfg_reg.pol[3]))
    else $error("reverse full-bridge static levels wrong");

  shut_override_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfg_reg.en && shut_reg && !is_steer
    |=> drive_out_a == $past(cfg_reg.ovr[0]) && drive_out_d == $past(cfg_reg.ovr[3]))
    else $error("shutdown override level not driven");
endmodule

// ==== verilog/cwm_pkg.sv ====
// Constants, register map and carrier types for the waveform mode core.
// Assumes a single 25 MHz clock domain; the Avalon-MM master is on that clock.
package cwm_pkg;
  localparam int CWM_AW = 6;
  localparam int CWM_DW = 32;
  localparam int CWM_DB_W = 6;
  localparam int CWM_NOUT = 4;
  localparam int CWM_NSRC = 8;
  localparam int CWM_SEL_W = 3;
  localparam int CWM_NSD = 2;

  // Byte offsets of the registers
  localparam logic [CWM_AW-1:0] CWM_OFS_CTRL0 = 6'h00;
  localparam logic [CWM_AW-1:0] CWM_OFS_CTRL1 = 6'h04;
  localparam logic [CWM_AW-1:0] CWM_OFS_DBR = 6'h08;
  localparam logic [CWM_AW-1:0] CWM_OFS_DBF = 6'h0C;
  localparam logic [CWM_AW-1:0] CWM_OFS_DBEN = 6'h10;
  localparam logic [CWM_AW-1:0] CWM_OFS_ISEL = 6'h14;
  localparam logic [CWM_AW-1:0] CWM_OFS_SHUT = 6'h18;
  localparam logic [CWM_AW-1:0] CWM_OFS_STEER = 6'h1C;
  localparam logic [CWM_AW-1:0] CWM_OFS_STAT = 6'h20;

  // Field positions
  localparam int CWM_EN_BIT = 7;
  localparam int CWM_DBR_EN_BIT = 0;
  localparam int CWM_DBF_EN_BIT = 1;
  localparam int CWM_SD_EN_LSB = 0;
  localparam int CWM_SD_SW_BIT = 2;
  localparam int CWM_AUTO_BIT = 3;
  localparam int CWM_OVR_LSB = 4;
  localparam int CWM_SHUT_BIT = 8;
  localparam int CWM_SDAT_LSB = 4;

  // Mode codes
  localparam logic [2:0] CWM_MODE_ASYNC = 3'h0;
  localparam logic [2:0] CWM_MODE_SYNC = 3'h1;
  localparam logic [2:0] CWM_MODE_FWD = 3'h2;
  localparam logic [2:0] CWM_MODE_REV = 3'h3;
  localparam logic [2:0] CWM_MODE_HB_DEF = 3'h4;
  localparam logic [2:0] CWM_MODE_PP_DEF = 3'h5;
  localparam logic [1:0] CWM_FB_HI = 2'h1;

  // Reset value of the output polarity bits: all active-high
  localparam logic [CWM_NOUT-1:0] CWM_POL_RST = 4'hF;

  typedef struct packed {
    logic en;
    logic [2:0] mode;
    logic [CWM_NOUT-1:0] pol;
    logic [CWM_DB_W-1:0] dbr;
    logic [CWM_DB_W-1:0] dbf;
    logic dbr_en;
    logic dbf_en;
    logic [CWM_SEL_W-1:0] isel;
    logic [CWM_NSD-1:0] sd_en;
    logic sd_sw;
    logic auto_rst;
    logic [CWM_NOUT-1:0] ovr;
    logic [CWM_NOUT-1:0] str;
    logic [CWM_NOUT-1:0] sdat;
  } cwm_cfg_s;

  typedef struct packed {
    logic read;
    logic write;
    logic [CWM_AW-1:0] address;
    logic [CWM_DW-1:0] writedata;
  } cwm_av_req_s;
endpackage

// ==== bench/cwm_drv_model.sv ====
// Model of the bridge switch drivers hanging on the four drive outputs.
// Assumes A/B share one bridge leg and C/D the other; pol gives each output's active level.
`timescale 1ns/1ps
module cwm_drv_model (
  input wire logic ref_clk,
  input wire logic armed,
  input wire logic [3:0] pol,
  input wire logic drive_out_a,
  input wire logic drive_out_b,
  input wire logic drive_out_c,
  input wire logic drive_out_d,
  output logic [15:0] fault_cnt
);
  logic [3:0] sw_on;

  assign sw_on = {drive_out_d, drive_out_c, drive_out_b, drive_out_a} ~^ pol;

  initial fault_cnt = 16'h0000;

  // Both switches of one leg on at once would short the supply
  always @(posedge ref_clk)
  begin
    if (armed && ((sw_on[0] && sw_on[1]) || (sw_on[2] && sw_on[3])))
    begin
      fault_cnt <= fault_cnt + 16'h0001;
    end
  end
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the waveform mode core with a switch driver model.
// Assumes the core's default half-bridge and push-pull codes.
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb;
  import cwm_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  cwm_av_req_s req = '0;
  logic [31:0] rdata;
  logic waitreq;
  logic [7:0] pulse_src = 8'h00;
  logic [1:0] sd_src = 2'h0;
  logic da, db, dc, dd, sd_act;
  logic [3:0] drv, pol, str, sdat, ovr;
  logic [2:0] isel = 3'h0;
  logic pin = 1'b0;
  logic armed = 1'b0;
  logic [15:0] faults;
  logic [31:0] q;
  int error_cnt = 0;
  int checked = 0;
  int dbr, dbf, t, g, sdi;

  assign drv = {dd, dc, db, da};
  always #20 ref_clk = ~ref_clk;
  // Unselected sources carry noise so a wrong select shows up
  always @(posedge ref_clk)
    pulse_src <= (8'($urandom) & ~(8'h01 << isel)) | ({7'h00, pin} << isel);

  cwm_core dut (.ref_clk(ref_clk), .reset_n(reset_n), .avs_req(req), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .pulse_src(pulse_src), .shutdown_src(sd_src),
    .drive_out_a(da), .drive_out_b(db), .drive_out_c(dc), .drive_out_d(dd),
    .shutdown_active(sd_act));
  cwm_drv_model sw (.ref_clk(ref_clk), .armed(armed), .pol(pol), .drive_out_a(da),
    .drive_out_b(db), .drive_out_c(dc), .drive_out_d(dd), .fault_cnt(faults));

  function automatic logic [3:0] model(logic [2:0] m, logic p, logic ppb);
    logic [3:0] act;
    case (m)
      CWM_MODE_FWD: act = {p, 1'b0, 1'b0, 1'b1};
      CWM_MODE_REV: act = {1'b0, 1'b1, p, 1'b0};
      CWM_MODE_HB_DEF: act = {~p, p, ~p, p};
      CWM_MODE_PP_DEF: act = ppb ? {p, 1'b0, p, 1'b0} : {1'b0, p, 1'b0, p};
      CWM_MODE_ASYNC, CWM_MODE_SYNC: return (str & ({4{p}} ~^ pol)) | (~str & sdat);
      default: act = 4'h0;
    endcase
    return act ~^ pol;
  endfunction

  task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req.read <= ~wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= d;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 40);
    q = rdata;
    `CHK(n < 40, 1'b1)
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0000_0000);
    `CHK(q, e)
  endtask

  task automatic settle();
    repeat (16) @(posedge ref_clk);
  endtask

  task automatic set_pin(input logic v);
    pin <= v;
    settle();
  endtask

  task automatic cfg(input logic [2:0] m, input logic en);
    wr(CWM_OFS_CTRL0, {24'h0, en, 4'h0, m});
  endtask

  task automatic chk_drv(input logic [2:0] m, input logic ppb);
    `CHK(drv, model(m, pin, ppb))
  endtask

  // Cycles until output i reaches its active (act=1) or inactive level
  task automatic wait_on(input int i, input logic act, output int n);
    n = 0;
    while (drv[i] !== (act ~^ pol[i]) && n < 60)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHK(n < 60, 1'b1)
  endtask

  task automatic give_verdict();
    $display("checked %0d, error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    give_verdict();
  end

  initial
  begin
    pol = CWM_POL_RST;
    void'($urandom(40731));
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    `CHK(drv, 4'h0)
    rd_chk(CWM_OFS_CTRL0, 32'h0000_0000);
    rd_chk(CWM_OFS_CTRL1, {28'h0, CWM_POL_RST});
    wr(6'h3C, 32'hFFFF_FFFF);
    rd_chk(6'h3C, 32'h0000_0000);
    $display("test registers finished");
    // Every mode code, each output with a fresh polarity and steering pattern
    wr(CWM_OFS_DBR, 32'(1 + $urandom % 4));
    wr(CWM_OFS_DBF, 32'(1 + $urandom % 4));
    wr(CWM_OFS_DBEN, 32'h0000_0003);
    for (int m = 0; m < 8; m++)
    begin
      cfg(3'h0, 1'b0);
      pol = 4'($urandom);
      str = 4'($urandom);
      sdat = 4'($urandom);
      isel = 3'($urandom);
      wr(CWM_OFS_CTRL1, {28'h0, pol});
      wr(CWM_OFS_STEER, {24'h0, sdat, str});
      wr(CWM_OFS_ISEL, {29'h0, isel});
      cfg(3'(m), 1'b1);
      settle();
      if (m != 1)
        chk_drv(3'(m), 1'b0);
      set_pin(1'b1);
      chk_drv(3'(m), 1'b0);
      set_pin(1'b0);
      chk_drv(3'(m), 1'b0);
    end
    // Synchronous steering keeps the old selection until the next input rise
    cfg(3'h0, 1'b0);
    str = 4'h0;
    sdat = pol;
    wr(CWM_OFS_STEER, {24'h0, sdat, str});
    cfg(CWM_MODE_SYNC, 1'b1);
    wr(CWM_OFS_STEER, {24'h0, sdat, 4'hF});
    settle();
    chk_drv(CWM_MODE_SYNC, 1'b0);
    str = 4'hF;
    set_pin(1'b1);
    chk_drv(CWM_MODE_SYNC, 1'b0);
    set_pin(1'b0);
    chk_drv(CWM_MODE_SYNC, 1'b0);
    $display("test mode sweep finished");
    // Half-bridge dead band on both edges, last pass with the timers disabled
    cfg(3'h0, 1'b0);
    pol = 4'($urandom);
    wr(CWM_OFS_CTRL1, {28'h0, pol});
    cfg(CWM_MODE_HB_DEF, 1'b1);
    settle();
    armed <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      dbr = $urandom % 11;
      dbf = $urandom % 11;
      wr(CWM_OFS_DBR, 32'(dbr));
      wr(CWM_OFS_DBF, 32'(dbf));
      wr(CWM_OFS_DBEN, (k == 3) ? 32'h0000_0000 : 32'h0000_0003);
      if (k == 3)
      begin
        dbr = 0;
        dbf = 0;
      end
      pin <= 1'b1;
      wait_on(1, 1'b0, t);
      wait_on(0, 1'b1, g);
      `CHK(g >= dbr && g <= dbr + 1, 1'b1)
      settle();
      pin <= 1'b0;
      wait_on(0, 1'b0, t);
      wait_on(1, 1'b1, g);
      `CHK(g >= dbf && g <= dbf + 1, 1'b1)
      settle();
    end
    armed <= 1'b0;
    $display("test half bridge finished");
    // Direction changes while running, high input held through the change
    cfg(3'h0, 1'b0);
    dbr = 2 + $urandom % 6;
    dbf = 2 + $urandom % 6;
    wr(CWM_OFS_DBR, 32'(dbr));
    wr(CWM_OFS_DBF, 32'(dbf));
    wr(CWM_OFS_DBEN, 32'h0000_0003);
    cfg(CWM_MODE_FWD, 1'b1);
    set_pin(1'b1);
    armed <= 1'b1;
    cfg(CWM_MODE_REV, 1'b1);
    settle();
    chk_drv(CWM_MODE_FWD, 1'b0);
    set_pin(1'b0);
    pin <= 1'b1;
    wait_on(2, 1'b1, t);
    `CHK(drv[0], ~pol[0])
    wait_on(1, 1'b1, g);
    `CHK(g >= dbr && g <= dbr + 1, 1'b1)
    settle();
    chk_drv(CWM_MODE_REV, 1'b0);
    cfg(CWM_MODE_FWD, 1'b1);
    set_pin(1'b0);
    pin <= 1'b1;
    wait_on(0, 1'b1, t);
    `CHK(drv[2], ~pol[2])
    wait_on(3, 1'b1, g);
    `CHK(g >= dbf && g <= dbf + 1, 1'b1)
    settle();
    chk_drv(CWM_MODE_FWD, 1'b0);
    armed <= 1'b0;
    set_pin(1'b0);
    $display("test full bridge finished");
    // Push-pull alternation, then a shutdown that must restart the sequence on A
    cfg(3'h0, 1'b0);
    pol = 4'($urandom);
    ovr = 4'($urandom);
    sdi = $urandom % 2;
    wr(CWM_OFS_CTRL1, {28'h0, pol});
    wr(CWM_OFS_SHUT, {24'h0, ovr, 2'h0, 2'(1 << sdi)});
    cfg(CWM_MODE_PP_DEF, 1'b1);
    settle();
    for (int j = 0; j < 3; j++)
    begin
      set_pin(1'b1);
      chk_drv(CWM_MODE_PP_DEF, 1'(j % 2));
      set_pin(1'b0);
    end
    sd_src[sdi] <= 1'b1;
    settle();
    `CHK(drv, ovr)
    `CHK(sd_act, 1'b1)
    sd_src <= 2'h0;
    settle();
    wr(CWM_OFS_SHUT, {23'h0, 1'b1, ovr, 2'h0, 2'(1 << sdi)});
    settle();
    `CHK(sd_act, 1'b0)
    set_pin(1'b1);
    chk_drv(CWM_MODE_PP_DEF, 1'b0);
    set_pin(1'b0);
    // Auto-restart: shutdown outlives its source and ends at the next input rise
    wr(CWM_OFS_SHUT, {24'h0, ovr, 2'h2, 2'(1 << sdi)});
    sd_src[sdi] <= 1'b1;
    settle();
    `CHK(sd_act, 1'b1)
    sd_src <= 2'h0;
    settle();
    `CHK(sd_act, 1'b1)
    `CHK(drv, ovr)
    set_pin(1'b1);
    `CHK(sd_act, 1'b0)
    set_pin(1'b0);
    `CHK(faults, 16'h0000)
    $display("test push pull finished");
    give_verdict();
  end
endmodule
